/* File: inc/rodpu_pkg.sv */
// shared constants and types of the rom/otp data patch unit
package rodpu_pkg;

	// -----------------------------------------------------------------
	// address map
	// -----------------------------------------------------------------
	localparam logic [31:0] LOW_LO  = 32'h00000000;
	localparam logic [31:0] LOW_HI  = 32'h0001FFFF;
	localparam logic [31:0] ROM_LO  = 32'h07F00000;
	localparam logic [31:0] ROM_HI  = 32'h07F1FFFF;
	localparam logic [31:0] OTP_LO  = 32'h07F80000;
	localparam logic [31:0] OTP_HI  = 32'h07F8FFFF;
	localparam logic [31:0] RAM_LO  = 32'h07FC0000;
	localparam logic [31:0] RAM_HI  = 32'h07FD7FFF;
	localparam logic [31:0] PREG_LO = 32'h40080000;
	localparam logic [31:0] PREG_HI = 32'h400803FF;

	// -----------------------------------------------------------------
	// register window
	// -----------------------------------------------------------------
	localparam int unsigned N_ENT   = 2;
	localparam int unsigned AW      = 10;
	localparam logic [9:0]  OFS_MATCH0 = 10'h000;
	localparam logic [9:0]  OFS_WORD0  = 10'h004;
	localparam logic [9:0]  OFS_ENT_STEP = 10'h008;
	localparam logic [9:0]  OFS_VALID  = 10'h010;
	localparam logic [9:0]  OFS_REMAP  = 10'h014;
	localparam logic [9:0]  OFS_STATUS = 10'h018;
	localparam logic [31:0] MATCH_RST  = 32'h00000000;
	localparam logic [31:0] WORD_RST   = 32'h00000000;
	localparam logic [1:0]  VALID_RST  = 2'h0;
	localparam logic [1:0]  REMAP_RST  = 2'h0;
	localparam logic [1:0]  REMAP_ROM  = 2'h0;
	localparam logic [1:0]  REMAP_OTP  = 2'h1;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam int unsigned TRANS_ACT_BIT = 1;

	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		RG_NONE, RG_ROM, RG_OTP, RG_RAM, RG_PREG
	} rodpu_region_t;

	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic        hready;
		logic        dma;
	} rodpu_ahb_ap_t;

	typedef struct packed {
		logic [AW-1:0] awaddr;
		logic          awvalid;
		logic [31:0]   wdata;
		logic [3:0]    wstrb;
		logic          wvalid;
		logic          bready;
		logic [AW-1:0] araddr;
		logic          arvalid;
		logic          rready;
	} rodpu_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} rodpu_axil_rsp_t;

endpackage

/* File: hw/rodpu_region_dec.sv */
// address-phase region decoder with low-window remap
`timescale 1ns/100ps
module rodpu_region_dec (
	input  wire logic [31:0]           addr,
	input  wire logic [1:0]            remap,
	output rodpu_pkg::rodpu_region_t   region
);

	always_comb
	begin
		region = rodpu_pkg::RG_NONE;
		if (addr <= rodpu_pkg::LOW_HI)
		begin
			// alias window follows the remap field
			unique case (remap)
				rodpu_pkg::REMAP_ROM: region = rodpu_pkg::RG_ROM;
				rodpu_pkg::REMAP_OTP: region = rodpu_pkg::RG_OTP;
				default:              region = rodpu_pkg::RG_RAM;
			endcase
		end
		else if (addr >= rodpu_pkg::ROM_LO && addr <= rodpu_pkg::ROM_HI)
			region = rodpu_pkg::RG_ROM;
		else if (addr >= rodpu_pkg::OTP_LO && addr <= rodpu_pkg::OTP_HI)
			region = rodpu_pkg::RG_OTP;
		else if (addr >= rodpu_pkg::RAM_LO && addr <= rodpu_pkg::RAM_HI)
			region = rodpu_pkg::RG_RAM;
		else if (addr >= rodpu_pkg::PREG_LO && addr <= rodpu_pkg::PREG_HI)
			region = rodpu_pkg::RG_PREG;
	end

endmodule // rodpu_region_dec

/* File: hw/rodpu_top.sv */
// data patch unit: register file, address match and read data swap
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps

// Contract
// - every cpu transfer address is compared with each entry's match address.
// - enabled matching entry returns its replacement word instead of memory.
// - when both entries match, entry 1 wins.
// - only rom and otp reads are substituted; others pass unchanged.
// - 0x07F00000..0x07F1FFFF is patchable rom.
// - 0x07F80000..0x07F8FFFF is patchable otp.
// - low window at 0x00000000 targets rom, otp or ram per remap field.
// - 0x40080000..0x400803FF is routed to the patch registers.
// - one enable bit per entry; a clear bit never substitutes.
// - two entries, each a 32-bit match address and 32-bit word.
// - only cpu transfers are patched; dma reads see original data.
module rodpu_top (
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	input  wire rodpu_pkg::rodpu_axil_req_t  axi_req,
	output rodpu_pkg::rodpu_axil_rsp_t       axi_rsp,
	input  wire rodpu_pkg::rodpu_ahb_ap_t    ahb_ap,
	input  wire logic [31:0]                 mem_rdata,
	output logic [31:0]                      cpu_rdata,
	output rodpu_pkg::rodpu_region_t         dp_region,
	output logic [1:0]                       dp_hit
);

	typedef struct packed {
		logic [1:0][31:0]        match;
		logic [1:0][31:0]        word;
		logic [1:0]              valid;
		logic [1:0]              remap;
		logic                    aw_ok;
		logic                    w_ok;
		logic [9:0]              awaddr;
		logic [31:0]             wdata;
		logic [3:0]              wstrb;
		rodpu_pkg::rodpu_axil_rsp_t rsp;
		logic                    dp_sel;
		logic [31:0]             dp_word;
		rodpu_pkg::rodpu_region_t region;
		logic [1:0]              hit;
		logic [1:0]              last_hit;
	} rodpu_state_t;

	localparam rodpu_state_t ST_RST = '{
		match:    {rodpu_pkg::MATCH_RST, rodpu_pkg::MATCH_RST},
		word:     {rodpu_pkg::WORD_RST, rodpu_pkg::WORD_RST},
		valid:    rodpu_pkg::VALID_RST,
		remap:    rodpu_pkg::REMAP_RST,
		aw_ok:    1'b0,
		w_ok:     1'b0,
		awaddr:   10'h000,
		wdata:    32'h00000000,
		wstrb:    4'h0,
		rsp:      '{awready: 1'b1, wready: 1'b1, bresp: 2'h0,
		            bvalid: 1'b0, arready: 1'b1, rdata: 32'h00000000,
		            rresp: 2'h0, rvalid: 1'b0},
		dp_sel:   1'b0,
		dp_word:  32'h00000000,
		region:   rodpu_pkg::RG_NONE,
		hit:      2'h0,
		last_hit: 2'h0
	};

	rodpu_state_t             s_q;
	rodpu_state_t             s_d;
	rodpu_pkg::rodpu_region_t ap_region;
	logic [1:0]               ap_hit;
	logic                     ap_take;
	logic                     ap_elig;

	// -----------------------------------------------------------------
	// address phase
	// -----------------------------------------------------------------
	rodpu_region_dec u_dec (
		.addr   (ahb_ap.haddr),
		.remap  (s_q.remap),
		.region (ap_region)
	);

	for (genvar i = 0; i < rodpu_pkg::N_ENT; i++)
	begin : g_cmp
		// word compare gated by the entry enable
		assign ap_hit[i] = s_q.valid[i]
			&& (s_q.match[i][31:2] == ahb_ap.haddr[31:2]);
	end

	assign ap_take = ahb_ap.hready && ahb_ap.htrans[rodpu_pkg::TRANS_ACT_BIT];
	// cpu rom/otp reads only
	assign ap_elig = !ahb_ap.hwrite && !ahb_ap.dma
		&& (ap_region == rodpu_pkg::RG_ROM || ap_region == rodpu_pkg::RG_OTP);

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = new_v[8*b +: 8];
		return r;
	endfunction

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb
	begin
		logic        wr_hit;
		logic        rd_hit;
		logic [9:0]  ofs;
		s_d = s_q;
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		ofs = 10'h000;

		// register write: address and data in either order
		if (s_q.rsp.awready && axi_req.awvalid)
		begin
			s_d.awaddr = axi_req.awaddr;
			s_d.aw_ok = 1'b1;
		end
		if (s_q.rsp.wready && axi_req.wvalid)
		begin
			s_d.wdata = axi_req.wdata;
			s_d.wstrb = axi_req.wstrb;
			s_d.w_ok = 1'b1;
		end
		if (s_q.rsp.bvalid && axi_req.bready)
			s_d.rsp.bvalid = 1'b0;
		if (s_q.aw_ok && s_q.w_ok && !s_q.rsp.bvalid)
		begin
			for (int i = 0; i < rodpu_pkg::N_ENT; i++)
			begin
				ofs = rodpu_pkg::OFS_MATCH0 + 10'(i) * rodpu_pkg::OFS_ENT_STEP;
				if (s_q.awaddr[9:2] == ofs[9:2])
				begin
					s_d.match[i] = merge(s_q.match[i], s_q.wdata, s_q.wstrb);
					wr_hit = 1'b1;
				end
				ofs = rodpu_pkg::OFS_WORD0 + 10'(i) * rodpu_pkg::OFS_ENT_STEP;
				if (s_q.awaddr[9:2] == ofs[9:2])
				begin
					s_d.word[i] = merge(s_q.word[i], s_q.wdata, s_q.wstrb);
					wr_hit = 1'b1;
				end
			end
			if (s_q.awaddr[9:2] == rodpu_pkg::OFS_VALID[9:2])
			begin
				if (s_q.wstrb[0])
					s_d.valid = s_q.wdata[1:0];
				wr_hit = 1'b1;
			end
			if (s_q.awaddr[9:2] == rodpu_pkg::OFS_REMAP[9:2])
			begin
				if (s_q.wstrb[0])
					s_d.remap = s_q.wdata[1:0];
				wr_hit = 1'b1;
			end
			if (s_q.awaddr[9:2] == rodpu_pkg::OFS_STATUS[9:2])
				wr_hit = 1'b1;
			s_d.rsp.bresp = wr_hit ? rodpu_pkg::RESP_OKAY
				: rodpu_pkg::RESP_SLVERR;
			s_d.rsp.bvalid = 1'b1;
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
		end
		s_d.rsp.awready = !s_d.aw_ok;
		s_d.rsp.wready = !s_d.w_ok;

		// register read
		if (s_q.rsp.rvalid && axi_req.rready)
			s_d.rsp.rvalid = 1'b0;
		if (s_q.rsp.arready && axi_req.arvalid)
		begin
			s_d.rsp.rdata = 32'h00000000;
			for (int i = 0; i < rodpu_pkg::N_ENT; i++)
			begin
				ofs = rodpu_pkg::OFS_MATCH0 + 10'(i) * rodpu_pkg::OFS_ENT_STEP;
				if (axi_req.araddr[9:2] == ofs[9:2])
				begin
					s_d.rsp.rdata = s_q.match[i];
					rd_hit = 1'b1;
				end
				ofs = rodpu_pkg::OFS_WORD0 + 10'(i) * rodpu_pkg::OFS_ENT_STEP;
				if (axi_req.araddr[9:2] == ofs[9:2])
				begin
					s_d.rsp.rdata = s_q.word[i];
					rd_hit = 1'b1;
				end
			end
			if (axi_req.araddr[9:2] == rodpu_pkg::OFS_VALID[9:2])
			begin
				s_d.rsp.rdata[1:0] = s_q.valid;
				rd_hit = 1'b1;
			end
			if (axi_req.araddr[9:2] == rodpu_pkg::OFS_REMAP[9:2])
			begin
				s_d.rsp.rdata[1:0] = s_q.remap;
				rd_hit = 1'b1;
			end
			if (axi_req.araddr[9:2] == rodpu_pkg::OFS_STATUS[9:2])
			begin
				s_d.rsp.rdata[1:0] = s_q.last_hit;
				rd_hit = 1'b1;
			end
			s_d.rsp.rresp = rd_hit ? rodpu_pkg::RESP_OKAY
				: rodpu_pkg::RESP_SLVERR;
			s_d.rsp.rvalid = 1'b1;
		end
		s_d.rsp.arready = !s_d.rsp.rvalid;

		// data phase select, held while the bus is stalled
		if (ahb_ap.hready)
		begin
			s_d.dp_sel = 1'b0;
			s_d.hit = 2'h0;
			s_d.region = ap_take ? ap_region : rodpu_pkg::RG_NONE;
			if (ap_take && ap_elig && ap_hit != 2'h0)
			begin
				s_d.dp_sel = 1'b1;
				// higher entry wins
				s_d.hit = ap_hit[1] ? 2'h2 : 2'h1;
				s_d.dp_word = ap_hit[1] ? s_q.word[1] : s_q.word[0];
				s_d.last_hit = s_d.hit;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			s_q <= ST_RST;
		else
			s_q <= s_d;
	end

	assign axi_rsp = s_q.rsp;
	assign dp_region = s_q.region;
	assign dp_hit = s_q.hit;
	// zero-wait swap on the data phase bus
	assign cpu_rdata = s_q.dp_sel ? s_q.dp_word : mem_rdata;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	AST_MATCH: assert property (ap_take && ap_elig
		&& ap_hit == 2'h1 |=> cpu_rdata == $past(s_q.word[0]))
		else $error("entry 0 match not substituted");
	AST_PRIO: assert property (ap_take && ap_elig
		&& ap_hit == 2'h3
		|=> dp_hit == 2'h2 && cpu_rdata == $past(s_q.word[1]))
		else $error("entry 1 did not win");
	AST_PASS: assert property (ap_take && !ap_elig
		|=> cpu_rdata == mem_rdata)
		else $error("non rom/otp read altered");
	AST_ROM: assert property (ap_take
		&& ahb_ap.haddr inside {[rodpu_pkg::ROM_LO:rodpu_pkg::ROM_HI]}
		|=> dp_region == rodpu_pkg::RG_ROM)
		else $error("rom decode wrong");
	AST_OTP: assert property (ap_take
		&& ahb_ap.haddr inside {[rodpu_pkg::OTP_LO:rodpu_pkg::OTP_HI]}
		|=> dp_region == rodpu_pkg::RG_OTP)
		else $error("otp decode wrong");
	AST_LOW: assert property (ap_take
		&& ahb_ap.haddr <= rodpu_pkg::LOW_HI
		&& s_q.remap == rodpu_pkg::REMAP_OTP
		|=> dp_region == rodpu_pkg::RG_OTP)
		else $error("low window remap wrong");
	AST_PREG: assert property (ap_take
		&& ahb_ap.haddr inside {[rodpu_pkg::PREG_LO:rodpu_pkg::PREG_HI]}
		|=> dp_region == rodpu_pkg::RG_PREG)
		else $error("patch register window decode wrong");
	AST_GATE: assert property (ap_take && s_q.valid == 2'h0
		|=> dp_hit == 2'h0)
		else $error("disabled entry substituted");
	AST_DMA: assert property (ap_take && ahb_ap.dma
		|=> cpu_rdata == mem_rdata)
		else $error("dma read patched");
	AST_RST: assert property ($past(rst) |-> s_q.valid == 2'h0
		&& !s_q.dp_sel)
		else $error("entries enabled after reset");
	AST_HOLD: assert property (s_q.dp_sel && !ahb_ap.hready
		|=> s_q.dp_sel && $stable(cpu_rdata))
		else $error("substitution dropped during wait");

endmodule // rodpu_top

/* File: test/rodpu_mem_model.sv */
// memory read data model for the ahb data phase
`timescale 1ns/100ps
module rodpu_mem_model (
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire rodpu_pkg::rodpu_ahb_ap_t ahb_ap,
	output logic [31:0]                   mem_rdata
);
	logic [31:0] addr_q;
	logic [31:0] cnt_q;
	logic        act_q;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			addr_q <= 32'h0;
			act_q  <= 1'b0;
			cnt_q  <= 32'h0;
		end
		else
		begin
			cnt_q <= cnt_q + 32'h1;
			if (ahb_ap.hready)
			begin
				addr_q <= ahb_ap.haddr;
				act_q  <= ahb_ap.htrans[1];
			end
		end
	end

	// idle phases show a moving pattern, never stale data
	assign mem_rdata = act_q ? ~addr_q : cnt_q;
endmodule // rodpu_mem_model

/* File: test/rom_otp_data_patch_unit_test.sv */
// self-checking bench of the data patch unit
`timescale 1ns/100ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module rom_otp_data_patch_unit_test;
	localparam logic [31:0] A0 = 32'h07F00040;
	localparam logic [31:0] W0 = 32'hC0DE0000;
	localparam logic [31:0] W1 = 32'h0000BEEF;
	localparam logic [1:0]  OK = 2'h0;
	logic                       core_clk;
	logic                       rst;
	rodpu_pkg::rodpu_axil_req_t rq;
	rodpu_pkg::rodpu_axil_rsp_t rs;
	rodpu_pkg::rodpu_ahb_ap_t   ap;
	logic [31:0]                mem_rdata;
	logic [31:0]                cpu_rdata;
	rodpu_pkg::rodpu_region_t   dp_region;
	logic [1:0]                 dp_hit;
	rodpu_pkg::rodpu_region_t   lr [3];
	int                         n_mismatch;
	int                         num_checks;
	int                         k;

	rodpu_top dut (
		.core_clk  (core_clk),
		.rst       (rst),
		.axi_req   (rq),
		.axi_rsp   (rs),
		.ahb_ap    (ap),
		.mem_rdata (mem_rdata),
		.cpu_rdata (cpu_rdata),
		.dp_region (dp_region),
		.dp_hit    (dp_hit)
	);

	rodpu_mem_model mem (
		.core_clk  (core_clk),
		.rst       (rst),
		.ahb_ap    (ap),
		.mem_rdata (mem_rdata)
	);

	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic hang;
		n_mismatch++;
		$display("[ERR] wait exp answer got none");
		tally_and_finish();
	endtask

	task automatic axw(input logic [9:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int   i;
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge core_clk);
		rq.awaddr <= a;
		rq.wdata <= d;
		rq.awvalid <= 1'b1;
		rq.wvalid <= 1'b1;
		for (i = 0; i < 64 && (aw || w); i++)
		begin
			@(posedge core_clk);
			aw = aw && !rs.awready;
			w = w && !rs.wready;
			rq.awvalid <= aw;
			rq.wvalid <= w;
		end
		for (i = 0; i < 64 && !rs.bvalid; i++)
			@(posedge core_clk);
		if (i == 64 || aw || w)
			hang();
		`CHK("bresp", er, rs.bresp)
	endtask

	task automatic axr(input logic [9:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int i;
		@(posedge core_clk);
		rq.araddr <= a;
		rq.arvalid <= 1'b1;
		for (i = 0; i < 64; i++)
		begin
			@(posedge core_clk);
			if (rs.arready)
				break;
		end
		rq.arvalid <= 1'b0;
		for (i = 0; i < 64 && !rs.rvalid; i++)
			@(posedge core_clk);
		if (i == 64)
			hang();
		`CHK("rdata", ed, rs.rdata)
		`CHK("rresp", er, rs.rresp)
	endtask

	task automatic ahb(input logic [31:0] a, input logic wr,
		input logic dm, input logic [31:0] ed, input logic [1:0] eh,
		input rodpu_pkg::rodpu_region_t er);
		@(posedge core_clk);
		ap.haddr <= a;
		ap.htrans <= 2'h2;
		ap.hwrite <= wr;
		ap.dma <= dm;
		@(posedge core_clk);
		ap.htrans <= 2'h0;
		#1;
		`CHK("cpu_rdata", (eh == 2'h0) ? ~a : ed, cpu_rdata)
		`CHK("dp_hit", eh, dp_hit)
		`CHK("dp_region", er, dp_region)
	endtask

	initial
	begin
		rst = 1'b1;
		rq = '0;
		rq.wstrb = 4'hF;
		rq.bready = 1'b1;
		rq.rready = 1'b1;
		ap = '0;
		ap.hready = 1'b1;
		n_mismatch = 0;
		num_checks = 0;
		lr = '{rodpu_pkg::RG_ROM, rodpu_pkg::RG_OTP, rodpu_pkg::RG_RAM};
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		axr(rodpu_pkg::OFS_VALID, 32'h0, OK);
		axr(10'h3FC, 32'h0, rodpu_pkg::RESP_SLVERR);
		axw(10'h3FC, 32'h1, rodpu_pkg::RESP_SLVERR);
		ahb(A0, 1'b0, 1'b0, 32'h0, 2'h0, rodpu_pkg::RG_ROM);
		$display("test reset done");
		// address before word, enable last
		axw(10'h000, A0, OK);
		axw(10'h004, W0, OK);
		axw(10'h008, A0, OK);
		axw(10'h00C, W1, OK);
		axr(10'h008, A0, OK);
		axr(10'h00C, W1, OK);
		ahb(A0, 1'b0, 1'b0, 32'h0, 2'h0, rodpu_pkg::RG_ROM);
		axw(rodpu_pkg::OFS_VALID, 32'h1, OK);
		ahb(A0, 1'b0, 1'b0, W0, 2'h1, rodpu_pkg::RG_ROM);
		axw(rodpu_pkg::OFS_VALID, 32'h3, OK);
		ahb(A0, 1'b0, 1'b0, W1, 2'h2, rodpu_pkg::RG_ROM);
		ahb(A0, 1'b1, 1'b0, 32'h0, 2'h0, rodpu_pkg::RG_ROM);
		ahb(A0, 1'b0, 1'b1, 32'h0, 2'h0, rodpu_pkg::RG_ROM);
		// data phase stretched by one wait state
		@(posedge core_clk);
		ap.haddr <= A0;
		ap.htrans <= 2'h2;
		ap.hwrite <= 1'b0;
		ap.dma <= 1'b0;
		@(posedge core_clk);
		ap.htrans <= 2'h0;
		ap.hready <= 1'b0;
		#1;
		`CHK("cpu_rdata", W1, cpu_rdata)
		@(posedge core_clk);
		ap.hready <= 1'b1;
		#1;
		`CHK("cpu_rdata", W1, cpu_rdata)
		`CHK("dp_hit", 2'h2, dp_hit)
		`CHK("dp_region", rodpu_pkg::RG_ROM, dp_region)
		$display("test priority done");
		axw(rodpu_pkg::OFS_VALID, 32'h2, OK);
		axw(10'h008, 32'h07F8FFFC, OK);
		ahb(32'h07F8FFFC, 1'b0, 1'b0, W1, 2'h2, rodpu_pkg::RG_OTP);
		axw(10'h008, 32'h07F1FFFC, OK);
		ahb(32'h07F1FFFC, 1'b0, 1'b0, W1, 2'h2, rodpu_pkg::RG_ROM);
		axr(rodpu_pkg::OFS_STATUS, 32'h2, OK);
		axw(10'h008, 32'h07FC0000, OK);
		ahb(32'h07FC0000, 1'b0, 1'b0, 0, 2'h0, rodpu_pkg::RG_RAM);
		axw(10'h008, 32'h40080000, OK);
		ahb(32'h40080000, 1'b0, 1'b0, 0, 2'h0, rodpu_pkg::RG_PREG);
		ahb(32'h07F20000, 1'b0, 1'b0, 0, 2'h0, rodpu_pkg::RG_NONE);
		for (k = 0; k < 3; k++)
		begin
			axw(rodpu_pkg::OFS_REMAP, k, OK);
			ahb(32'h100, 1'b0, 1'b0, 0, 2'h0, lr[k]);
		end
		$display("test regions done");
		@(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		rst <= 1'b0;
		axr(rodpu_pkg::OFS_VALID, 32'h0, OK);
		axr(10'h000, 32'h0, OK);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule // rom_otp_data_patch_unit_test
